// ### dv/msem_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module msem_mem_model (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  req_vld,
	input  wire logic [2:0]            req_idx,
	input  wire logic                  req_unc,
	input  wire logic                  req_cor,
	input  wire logic [15:0]           req_addr,
	output var  msem_pkg::msem_evt_t   mem_evt [msem_pkg::NUM_MEM]
);
	import msem_pkg::*;
	// read-time upset pulses
	// idle address lines toggle so no stale value can pass for a real one
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < NUM_MEM; i++) begin
			if (!presetn) begin
				mem_evt[i] <= '0;
			end else begin
				mem_evt[i].uncorr <= req_vld && (req_idx == i[2:0]) && req_unc;
				mem_evt[i].corr   <= req_vld && (req_idx == i[2:0]) && req_cor;
				mem_evt[i].addr   <= (req_vld && req_idx == i[2:0]) ? req_addr : ~mem_evt[i].addr;
			end
		end
	end
endmodule : msem_mem_model
`default_nettype wire

// ### dv/msem_monitor_props.sv
`timescale 1ns/1ps
`default_nettype none
module msem_monitor_props (
	input wire logic                             pclk,
	input wire logic                             presetn,
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pwrite,
	input wire logic [7:0]                       paddr,
	input wire logic [31:0]                      prdata,
	input wire logic                             pready,
	input wire logic                             pslverr,
	input wire logic [msem_pkg::INTR_SRC_W-1:0]  intr_src_vec
);
	import msem_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	logic mapped;
	assign mapped = paddr inside {OFS_CTRL, OFS_STAT, OFS_INFO, OFS_IDX, OFS_DIV};
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_in_access: assert property (pready |-> s_access)
		else $error("pready outside access");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (s_setup ##1 (pready && !mapped) |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_no_err: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped access");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_intr_bit_only: assert property ((intr_src_vec & ~(32'h1 << INTR_INTEGRITY_INTERRUPT_SOURCE_BIT)) == 32'h0)
		else $error("interrupt outside its source bit");
	a_quiet_after_reset: assert property ($rose(presetn) |-> intr_src_vec == 32'h0)
		else $error("interrupt right after reset");
endmodule : msem_monitor_props
bind msem_monitor msem_monitor_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .intr_src_vec(intr_src_vec));
`default_nettype wire

// ### dv/tb_msem_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tb_msem_monitor;
	import msem_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, err, hv, hu, hc;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d, cbase;
	logic        pready, pslverr;
	logic [2:0]  hi;
	logic [15:0] ha;
	logic [31:0] intr_src_vec;
	msem_evt_t   mem_evt [NUM_MEM];
	int          num_errors, check_count;
	logic [31:0] e_idx [4] = '{32'h0, 32'h2, 32'h3, 32'h5};
	logic [31:0] e_inf [4] = '{32'h2000_00aa, 32'h9000_1234, 32'h4000_0000, 32'h9000_0f0f};
	logic [31:0] e_msk [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hf000_0000, 32'hffff_ffff};
	msem_monitor u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_evt(mem_evt), .intr_src_vec(intr_src_vec));
	msem_mem_model u_mem (.pclk(pclk), .presetn(presetn), .req_vld(hv), .req_idx(hi),
		.req_unc(hu), .req_cor(hc), .req_addr(ha), .mem_evt(mem_evt));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task report_and_stop();
		if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	// one apb transfer; waits for pready under a bound, released only after it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin num_errors++; report_and_stop(); end
		d = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask : apb
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		check(d, e);
	endtask : rd_chk
	// one step_state_one_shot, then poll busy; a step may last several cycles
	task step();
		apb(1, OFS_CTRL, cbase | 32'h1);
		settle();
	endtask : step
	// poll status until busy falls; d keeps the last status word
	task settle();
		int n;
		n = 0;
		do begin apb(0, OFS_STAT, 32'h0); n++; end while (d[STAT_BUSY_BIT] !== 1'b0 && n < 20);
		if (n >= 20) begin num_errors++; report_and_stop(); end
	endtask : settle
	task ev(input logic [2:0] i, input logic u, input logic c, input logic [15:0] a);
		hv <= 1; hi <= i; hu <= u; hc <= c; ha <= a;
		@(posedge pclk);
		hv <= 0;
		repeat (3) @(posedge pclk);
	endtask : ev
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		hv = 0; hi = 0; hu = 0; hc = 0; ha = 0; cbase = 0; num_errors = 0; check_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rd_chk(OFS_STAT, 32'h1);
		rd_chk(OFS_DIV, 32'h0000_00ff);
		apb(0, 8'h14, 32'h0);
		check({d[31:1], err}, 32'h1);
		apb(1, OFS_STAT, 32'h0);
		rd_chk(OFS_STAT, 32'h1);
		// fast divider before the first step_state_one_shot
		apb(1, OFS_DIV, 32'h0);
		apb(1, OFS_CTRL, 32'h1);
		rd_chk(OFS_STAT, 32'h9);
		settle();
		check(d, 32'h2);
		ev(3'd2, 1, 0, 16'h1234);
		ev(3'd2, 0, 1, 16'h5555);
		ev(3'd5, 0, 1, 16'habcd);
		ev(3'd5, 1, 0, 16'h0f0f);
		ev(3'd7, 0, 1, 16'h1111);
		ev(3'd0, 0, 1, 16'h00aa);
		rd_chk(OFS_STAT, 32'h12);
		check(intr_src_vec, 32'h1 << INTR_INTEGRITY_INTERRUPT_SOURCE_BIT);
		// readout walk: listen to idle, then on until listen
		step();
		rd_chk(OFS_STAT, 32'h1);
		check(intr_src_vec, 32'h0);
		ev(3'd3, 1, 0, 16'h7777);
		rd_chk(OFS_STAT, 32'h1);
		check(intr_src_vec, 32'h0);
		for (int k = 0; k < 4; k++) begin
			step();
			check(d, 32'h4);
			// every index seen here is a supported memory
			rd_chk(OFS_IDX, e_idx[k]);
			apb(0, OFS_INFO, 32'h0);
			check(d & e_msk[k], e_inf[k]);
		end
		step();
		check(d, 32'h2);
		rd_chk(OFS_INFO, 32'h0);
		// ring enable set only with the pcie side taken as enabled
		cbase = 32'h2;
		apb(1, OFS_CTRL, cbase);
		rd_chk(OFS_CTRL, 32'h2);
		ev(3'd7, 0, 1, 16'h2222);
		step();
		step();
		rd_chk(OFS_IDX, 32'h7);
		rd_chk(OFS_INFO, 32'h2000_2222);
		report_and_stop();
	end
endmodule : tb_msem_monitor
`default_nettype wire

// ### src/msem_monitor.sv
// Function
// - after reset the monitor sits idle and takes no reports
// - idle memories still store indications locally but report nothing
// - listen watches memories, sets indication flag and raises interrupt
// - detect presents one indication and its memory index
// - status shows idle, listen and detect as separate bits
// - writing one to step_state_one_shot steps the monitor to its next state
// - step_state_one_shot stays set and busy stays high through the transition
// - first step_state_one_shot clears all memory detection logic and goes to listen
// - each memory holds one indication, cleared once read out
// - an indication is four flags and one address
// - stored uncorrectable upset sets uncorrectable flag and address
// - stored correctable upset sets correctable flag and address
// - unstored upset sets the matching overflow flag
// - uncorrectable information takes priority over correctable
// - addresses captured only while listening, otherwise flags only
// - indications come from memory reads and reach the interrupt
// - device reset leaves memory indication storage untouched
// - interrupt sits at bit 21 of the source vector
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module msem_monitor (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire msem_pkg::msem_evt_t            mem_evt [msem_pkg::NUM_MEM],
	output logic      [msem_pkg::INTR_SRC_W-1:0] intr_src_vec
);
	import msem_pkg::*;

	// apb slave: one decode cycle, answer in the first access cycle
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;
	logic        wr_ok;
	logic        hit;

	// control and status state
	msem_state_t           state_reg, state_next;
	logic                  busy_reg, busy_next;
	logic                  first_done_reg, first_done_next;
	logic                  ring_ena_reg, ring_ena_next;
	logic [DIV_W-1:0]      div_reg, div_next;
	logic [DIV_W-1:0]      div_cnt_reg, div_cnt_next;
	logic [2:0]            step_reg, step_next;
	logic                  ind_reg, ind_next;
	msem_ind_t             info_reg, info_next;
	logic [MEM_IDX_W-1:0]  idx_reg, idx_next;
	logic [INTR_SRC_W-1:0] intr_reg, intr_next;

	// transition completion strobes toward the memories
	logic                  done;
	logic                  clr_all;
	logic [NUM_MEM-1:0]    clr_one;
	logic [NUM_MEM-1:0]    pend;
	logic                  any_pend;
	logic [MEM_IDX_W-1:0]  pick;
	msem_ind_t             store [NUM_MEM];

	assign wr_ok = psel & penable & pready_reg & pwrite;

	always_comb begin
		hit = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_INFO) ||
		      (paddr == OFS_IDX) || (paddr == OFS_DIV);
		pready_next  = psel & ~penable;
		pslverr_next = psel & ~penable & ~hit;
		prdata_next  = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL: begin
					prdata_next[CTRL_STEP_STATE_ONE_SHOT_BIT] = busy_reg;
					prdata_next[CTRL_RING_ENA_BIT] = ring_ena_reg;
				end
				OFS_STAT: begin
					prdata_next[STAT_IDLE_BIT]   = (state_reg == MSEM_IDLE);
					prdata_next[STAT_LISTEN_BIT] = (state_reg == MSEM_LISTEN);
					prdata_next[STAT_DETECT_BIT] = (state_reg == MSEM_DETECT);
					prdata_next[STAT_BUSY_BIT]   = busy_reg;
					prdata_next[STAT_IND_BIT]    = ind_reg;
				end
				OFS_INFO: begin
					prdata_next[INFO_UERR_BIT]    = info_reg.uerr;
					prdata_next[INFO_UOVF_BIT]    = info_reg.uovf;
					prdata_next[INFO_CERR_BIT]    = info_reg.cerr;
					prdata_next[INFO_COVF_BIT]    = info_reg.covf;
					prdata_next[MEM_ADDR_W-1:0]   = info_reg.addr;
				end
				OFS_IDX:  prdata_next[MEM_IDX_W-1:0] = idx_reg;
				OFS_DIV:  prdata_next[DIV_W-1:0]     = div_reg;
				default:  prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// lowest pending memory is presented first
	always_comb begin
		pick = '0;
		for (int k = NUM_MEM - 1; k >= 0; k--) begin
			if (pend[k]) begin
				pick = k[MEM_IDX_W-1:0];
			end
		end
	end
	assign any_pend = |pend;
	assign done     = busy_reg && (step_reg == STEP_TICKS - 3'h1) && (div_cnt_reg == div_reg);

	always_comb begin
		state_next      = state_reg;
		busy_next       = busy_reg;
		first_done_next = first_done_reg;
		ring_ena_next   = ring_ena_reg;
		div_next        = div_reg;
		div_cnt_next    = div_cnt_reg;
		step_next       = step_reg;
		info_next       = info_reg;
		idx_next        = idx_reg;
		clr_all         = 1'b0;
		clr_one         = '0;
		if (wr_ok && paddr == OFS_CTRL) begin
			ring_ena_next = pwdata[CTRL_RING_ENA_BIT];
			// step_state_one_shot starts a step; ignored while one runs
			if (pwdata[CTRL_STEP_STATE_ONE_SHOT_BIT] && !busy_reg) begin
				busy_next    = 1'b1;
				div_cnt_next = '0;
				step_next    = 3'h0;
			end
		end
		if (wr_ok && paddr == OFS_DIV) begin
			// divider sets the ring walk speed
			div_next = pwdata[DIV_W-1:0];
		end
		// busy held for the whole walk
		if (busy_reg && !done) begin
			if (div_cnt_reg == div_reg) begin
				div_cnt_next = '0;
				step_next    = step_reg + 3'h1;
			end else begin
				div_cnt_next = div_cnt_reg + 16'h0001;
			end
		end
		if (done) begin
			busy_next = 1'b0;
			case (state_reg)
				MSEM_LISTEN: state_next = MSEM_IDLE;
				MSEM_IDLE: begin
					if (!first_done_reg) begin
						// first step clears rings, goes to listen
						clr_all         = 1'b1;
						first_done_next = 1'b1;
						state_next      = MSEM_LISTEN;
					end else if (any_pend) begin
						state_next = MSEM_DETECT;
						info_next  = store[pick];
						idx_next   = pick;
					end else begin
						state_next = MSEM_LISTEN;
					end
				end
				MSEM_DETECT: begin
					clr_one[idx_reg] = 1'b1;
					if ((pend & ~clr_one) != '0) begin
						state_next = MSEM_DETECT;
						for (int k = NUM_MEM - 1; k >= 0; k--) begin
							if (pend[k] && k != int'(idx_reg)) begin
								idx_next  = k[MEM_IDX_W-1:0];
								info_next = store[k];
							end
						end
					end else begin
						state_next = MSEM_LISTEN;
						info_next  = '0;
					end
				end
				default: state_next = MSEM_IDLE;
			endcase
		end
	end

	// flag and interrupt only from listen; source bit
	always_comb begin
		ind_next                 = (state_reg == MSEM_LISTEN) && any_pend;
		intr_next                = '0;
		intr_next[INTR_INTEGRITY_INTERRUPT_SOURCE_BIT] = ind_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= MSEM_IDLE;
			busy_reg       <= 1'b0;
			first_done_reg <= 1'b0;
			ring_ena_reg   <= 1'b0;
			div_reg        <= DIV_RESET;
			div_cnt_reg    <= '0;
			step_reg       <= 3'h0;
			ind_reg        <= 1'b0;
			info_reg       <= '0;
			idx_reg        <= '0;
			intr_reg       <= '0;
		end else begin
			state_reg      <= state_next;
			busy_reg       <= busy_next;
			first_done_reg <= first_done_next;
			ring_ena_reg   <= ring_ena_next;
			div_reg        <= div_next;
			div_cnt_reg    <= div_cnt_next;
			step_reg       <= step_next;
			ind_reg        <= ind_next;
			info_reg       <= info_next;
			idx_reg        <= idx_next;
			intr_reg       <= intr_next;
		end
	end

	// per-memory indication storage
	genvar g;
	generate
		for (g = 0; g < NUM_MEM; g++) begin : g_mem
			msem_ind_t ind_reg_m, ind_next_m;
			logic      gate_ok;
			logic      listen;

			// pcie mac memories silent unless ring enabled
			assign gate_ok = (g < PCIE_MEM_BASE) || ring_ena_reg;
			assign listen  = (state_reg == MSEM_LISTEN);
			// idle memories keep but do not report
			assign pend[g]  = ind_reg_m.uerr | ind_reg_m.uovf |
			                  ind_reg_m.cerr | ind_reg_m.covf;
			assign store[g] = ind_reg_m;

			always_comb begin
				ind_next_m = ind_reg_m;
				if (clr_all || clr_one[g]) begin
					ind_next_m = '0;
				end
				// event after clear: a clear never drops an upset of the same cycle
				if (gate_ok && mem_evt[g].uncorr) begin
					if (listen && !ind_next_m.uerr) begin
						ind_next_m.uerr = 1'b1;
						ind_next_m.addr = mem_evt[g].addr;
						if (ind_next_m.cerr) begin
							ind_next_m.cerr = 1'b0;
							ind_next_m.covf = 1'b1;
						end
					end else begin
						ind_next_m.uovf = 1'b1;
					end
				end
				if (gate_ok && mem_evt[g].corr) begin
					if (listen && !mem_evt[g].uncorr && !ind_next_m.uerr &&
					    !ind_next_m.cerr) begin
						ind_next_m.cerr = 1'b1;
						ind_next_m.addr = mem_evt[g].addr;
					end else begin
						ind_next_m.covf = 1'b1;
					end
				end
			end

			// no reset: contents stand until cleared by the first step_state_one_shot
			always_ff @(posedge pclk) begin
				ind_reg_m <= ind_next_m;
			end
		end
	endgenerate

	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign intr_src_vec = intr_reg;

endmodule : msem_monitor

`default_nettype wire

// ### src/msem_pkg.sv
package msem_pkg;

	// memory ring shape; index values are arbitrary, memories at and above
	// the pcie base belong to the pcie mac and may be clock-gated
	localparam int unsigned NUM_MEM       = 8;
	localparam int unsigned MEM_IDX_W     = 3;
	localparam int unsigned MEM_ADDR_W    = 16;
	localparam int unsigned PCIE_MEM_BASE = 6;

	// register byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_INFO = 8'h08;
	localparam logic [7:0] OFS_IDX  = 8'h0c;
	localparam logic [7:0] OFS_DIV  = 8'h10;

	// control fields
	localparam int unsigned CTRL_STEP_STATE_ONE_SHOT_BIT = 0;
	localparam int unsigned CTRL_RING_ENA_BIT = 1;

	// status fields
	localparam int unsigned STAT_IDLE_BIT   = 0;
	localparam int unsigned STAT_LISTEN_BIT = 1;
	localparam int unsigned STAT_DETECT_BIT = 2;
	localparam int unsigned STAT_BUSY_BIT   = 3;
	localparam int unsigned STAT_IND_BIT    = 4;

	// indication info fields
	localparam int unsigned INFO_UERR_BIT = 31;
	localparam int unsigned INFO_UOVF_BIT = 30;
	localparam int unsigned INFO_CERR_BIT = 29;
	localparam int unsigned INFO_COVF_BIT = 28;

	// divider: reset value and the recommended fast value are plain defaults
	localparam int unsigned DIV_W       = 16;
	localparam logic [15:0] DIV_RESET   = 16'h00ff;
	localparam logic [2:0]  STEP_TICKS  = 3'h4;

	// interrupt controller source position
	localparam int unsigned INTR_SRC_W   = 32;
	localparam int unsigned INTR_INTEGRITY_INTERRUPT_SOURCE_BIT = 21;

	typedef enum logic [2:0] {
		MSEM_IDLE   = 3'b001,
		MSEM_LISTEN = 3'b010,
		MSEM_DETECT = 3'b100
	} msem_state_t;

	typedef struct packed {
		logic                  uncorr;
		logic                  corr;
		logic [MEM_ADDR_W-1:0] addr;
	} msem_evt_t;

	typedef struct packed {
		logic                  uerr;
		logic                  uovf;
		logic                  cerr;
		logic                  covf;
		logic [MEM_ADDR_W-1:0] addr;
	} msem_ind_t;

endpackage : msem_pkg
